//--- core/dmem_stack_pkg.sv
package dmem_stack_pkg;
    // memory sizes
    localparam int DMEM_BYTES = 1280;
    localparam int IRAM_BYTES = 256;
    localparam int EXT_BYTES = 1024;
    localparam logic [15:0] DMEM_LIMIT = 16'h0500;
    localparam int MEM_AW = 11;

    // stack and address map
    localparam logic [15:0] SP_RESET = 16'h0007;
    localparam logic [7:0] SFR_DIRECT_MIN = 8'h80;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] PC_MSB_MARK = 8'h80;
    localparam int PC_W = 23;
    localparam logic [1:0] FRAME_STD = 2'h2;
    localparam logic [1:0] FRAME_EXT = 2'h3;

    // register offsets (byte addresses)
    localparam logic [11:0] REG_MODE = 12'h000;
    localparam logic [11:0] REG_SP = 12'h004;
    localparam logic [11:0] REG_BANK = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;

    // field positions and reset values
    localparam int MODE_EIF_BIT = 0;
    localparam int MODE_ESM_BIT = 1;
    localparam int BANK_LO_BIT = 3;
    localparam int BANK_HI_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam logic [1:0] BANK_RESET = 2'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
        OP_REG_RD, OP_REG_WR, OP_BIT_RD, OP_BIT_WR,
        OP_UPTR_RD, OP_UPTR_WR, OP_PUSH, OP_POP,
        OP_CALL, OP_RET, OP_INTR, OP_INTERRUPT_RETURN_INSTRUCTION, OP_ECALL, OP_ERET
    } op_type;

    typedef struct packed {
        op_type op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [PC_W-1:0] pc;
    } core_req_type;

    typedef struct packed {
        logic [7:0] rdata;
        logic [PC_W-1:0] pc;
        logic sfr_route;
        logic range_err;
    } core_rsp_type;
endpackage

//--- core/dmem_stack.sv
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - 256-byte on-chip RAM serves direct and indirect accesses.
// - further 1024 bytes above it give 1280 bytes in total.
// - two bank bits pick working registers at 00h, 08h, 10h or 18h.
// - banks share physical RAM with direct and indirect addressing.
// - bytes 20h..2Fh also bit addressable, bit 00h..7Fh in order.
// - bit numbers above 127 are routed to special function registers.
// - extended RAM reached only by extended stack or universal pointers.
// - stack grows upward; pointer holds last pushed item.
// - push increments pointer first, then writes the byte.
// - pop reads the byte first, then decrements pointer.
// - default configuration stacks only low 16 program counter bits for call and interrupt.
// - reset disables extended interrupt frame and extended stack memory.
// - extended frame pushes 23-bit return address as three bytes, pops three.
// - top bit of stacked program counter high byte forced to one.
// - extended frame affects only interrupt entry and return.
// - extended call and return always use 23-bit return addresses.
// - extended interrupt frame enabled only by its mode bit.
// - extended stack memory widens stack pointer to 16 bits.
// - extended stack memory leaves stacked data format unchanged.
// - extended stack memory enabled only by its mode bit.
// - unloaded stack pointer places first item at address 8.
module dmem_stack
    import dmem_stack_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire core_req_type CORE_REQ,
    input wire logic CORE_REQ_VALID,
    output logic CORE_REQ_READY,
    output core_rsp_type CORE_RSP,
    output logic CORE_RSP_VALID
);

    typedef enum {ST_IDLE, ST_PUSH, ST_POP} state_type;

    // stack address as seen by memory, narrow unless extended stack is on
    function automatic logic [15:0] stack_index(input logic [15:0] sp, input logic esm);
        return esm ? sp : {8'h00, sp[7:0]};
    endfunction

    // pointer step, wrapping inside 256 bytes in classic mode
    function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic esm,
                                            input logic up);
        logic [15:0] nxt;
        nxt = up ? sp + 16'h0001 : sp - 16'h0001;
        return esm ? nxt : {8'h00, nxt[7:0]};
    endfunction

    // stacked bytes for a frame operation
    function automatic logic [1:0] frame_len(input op_type op, input logic eif);
        logic [1:0] len;
        len = FRAME_STD;
        if (op == OP_ECALL || op == OP_ERET) begin
            len = FRAME_EXT;
        end else if ((op == OP_INTR || op == OP_INTERRUPT_RETURN_INSTRUCTION) && eif) begin
            len = FRAME_EXT;
        end
        return len;
    endfunction

    logic [7:0] mem [DMEM_BYTES];
    state_type state_ff;
    core_req_type req_ff;
    logic [1:0] idx_ff;
    logic [1:0] left_ff;
    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic eif_ff;
    logic esm_ff;
    logic [1:0] bank_ff;
    logic err_ff;
    logic [PC_W-1:0] pc_acc_ff;
    core_rsp_type rsp_ff;
    logic rsp_valid_ff;
    logic accept;
    logic is_frame;
    logic mem_we;
    logic [15:0] mem_wa;
    logic [7:0] mem_wd;
    logic [15:0] rd_idx;
    logic [7:0] mem_rd;
    logic route_sfr;
    logic range_err;
    logic [7:0] bit_byte;
    logic [15:0] stk_idx;
    logic [15:0] stk_up_idx;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_wr;
    logic sp_load;
    logic [31:0] reg_rd;
    logic reg_hit;

    assign accept = CORE_REQ_VALID && state_ff == ST_IDLE;
    assign CORE_REQ_READY = state_ff == ST_IDLE;
    assign is_frame = CORE_REQ.op inside {OP_CALL, OP_RET, OP_INTR, OP_INTERRUPT_RETURN_INSTRUCTION,
                                          OP_ECALL, OP_ERET};
    assign stk_idx = stack_index(sp_ff, esm_ff);
    assign stk_up_idx = stack_index(sp_step(sp_ff, esm_ff, 1'b1), esm_ff);
    assign bit_byte = BIT_AREA_BASE + {4'h0, CORE_REQ.addr[6:3]};
    assign mem_rd = (rd_idx < DMEM_LIMIT) ? mem[rd_idx[MEM_AW-1:0]] : 8'h00;

    // access decode: one memory byte read and at most one written per cycle
    always_comb begin
        mem_we = 1'b0;
        mem_wa = 16'h0000;
        mem_wd = 8'h00;
        rd_idx = 16'h0000;
        nxt_sp = sp_ff;
        route_sfr = 1'b0;
        range_err = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    case (CORE_REQ.op)
                        OP_DIR_RD, OP_DIR_WR: begin
                            // upper direct half belongs to special function registers
                            route_sfr = CORE_REQ.addr[7:0] >= SFR_DIRECT_MIN;
                            rd_idx = {8'h00, CORE_REQ.addr[7:0]};
                            mem_we = CORE_REQ.op == OP_DIR_WR && !route_sfr;
                        end
                        OP_IND_RD, OP_IND_WR: begin
                            rd_idx = {8'h00, CORE_REQ.addr[7:0]};
                            mem_we = CORE_REQ.op == OP_IND_WR;
                        end
                        OP_REG_RD, OP_REG_WR: begin
                            // bank picks the eight-byte group, shared storage
                            rd_idx = {11'h000, bank_ff, CORE_REQ.addr[2:0]};
                            mem_we = CORE_REQ.op == OP_REG_WR;
                        end
                        OP_BIT_RD, OP_BIT_WR: begin
                            route_sfr = CORE_REQ.addr[7];
                            rd_idx = {8'h00, bit_byte};
                            mem_we = CORE_REQ.op == OP_BIT_WR && !route_sfr;
                        end
                        OP_UPTR_RD, OP_UPTR_WR: begin
                            // only path besides the stack into the upper 1024 bytes
                            range_err = CORE_REQ.addr >= DMEM_LIMIT;
                            rd_idx = CORE_REQ.addr;
                            mem_we = CORE_REQ.op == OP_UPTR_WR && !range_err;
                        end
                        OP_PUSH: begin
                            nxt_sp = sp_step(sp_ff, esm_ff, 1'b1);
                            range_err = stk_up_idx >= DMEM_LIMIT;
                            mem_we = !range_err;
                        end
                        OP_POP: begin
                            rd_idx = stk_idx;
                            range_err = stk_idx >= DMEM_LIMIT;
                            nxt_sp = sp_step(sp_ff, esm_ff, 1'b0);
                        end
                        default: begin
                        end
                    endcase
                    mem_wa = (CORE_REQ.op == OP_PUSH) ? stk_up_idx : rd_idx;
                    mem_wd = CORE_REQ.wdata;
                    if (CORE_REQ.op == OP_BIT_WR) begin
                        mem_wd = mem_rd;
                        mem_wd[CORE_REQ.addr[2:0]] = CORE_REQ.wdata[0];
                    end
                end
            end
            ST_PUSH: begin
                // one return-address byte per cycle, low byte first
                nxt_sp = sp_step(sp_ff, esm_ff, 1'b1);
                mem_wa = stk_up_idx;
                mem_we = stk_up_idx < DMEM_LIMIT;
                mem_wd = (idx_ff == 2'h2) ? (req_ff.pc[PC_W-1:16] | PC_MSB_MARK)
                       : (idx_ff == 2'h1) ? req_ff.pc[15:8] : req_ff.pc[7:0];
            end
            ST_POP: begin
                rd_idx = stk_idx;
                nxt_sp = sp_step(sp_ff, esm_ff, 1'b0);
            end
        endcase
    end

    // memory write port
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            mem[mem_wa[MEM_AW-1:0]] <= mem_wd;
        end
    end

    // sequencer for multi-byte return-address frames
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            idx_ff <= 2'h0;
            left_ff <= 2'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (accept && is_frame) begin
                        req_ff <= CORE_REQ;
                        left_ff <= frame_len(CORE_REQ.op, eif_ff);
                        if (CORE_REQ.op inside {OP_CALL, OP_INTR, OP_ECALL}) begin
                            state_ff <= ST_PUSH;
                            idx_ff <= 2'h0;
                        end else begin
                            state_ff <= ST_POP;
                            idx_ff <= frame_len(CORE_REQ.op, eif_ff) - 2'h1;
                        end
                    end
                end
                ST_PUSH: begin
                    idx_ff <= idx_ff + 2'h1;
                    left_ff <= left_ff - 2'h1;
                    if (left_ff == 2'h1) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_POP: begin
                    idx_ff <= idx_ff - 2'h1;
                    left_ff <= left_ff - 2'h1;
                    if (left_ff == 2'h1) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // return address assembled from popped bytes, high byte first
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_acc_ff <= '0;
        end else if (accept && is_frame) begin
            pc_acc_ff <= '0; // two-byte frames leave the upper 7 bits zero
        end else if (state_ff == ST_POP) begin
            unique case (idx_ff)
                2'h2: pc_acc_ff[PC_W-1:16] <= mem_rd[6:0];
                2'h1: pc_acc_ff[15:8] <= mem_rd;
                default: pc_acc_ff[7:0] <= mem_rd;
            endcase
        end
    end

    // core response, one cycle after the last byte
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rsp_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= (accept && !is_frame) || (state_ff != ST_IDLE && left_ff == 2'h1);
            if (accept && !is_frame) begin
                rsp_ff.rdata <= (CORE_REQ.op == OP_BIT_RD) ?
                                {7'h00, mem_rd[CORE_REQ.addr[2:0]]} : mem_rd;
                rsp_ff.sfr_route <= route_sfr;
                rsp_ff.range_err <= range_err;
                rsp_ff.pc <= '0;
            end else if (state_ff == ST_POP && left_ff == 2'h1) begin
                rsp_ff.pc <= {pc_acc_ff[PC_W-1:8], mem_rd};
                rsp_ff.sfr_route <= 1'b0;
                rsp_ff.range_err <= 1'b0;
            end else if (state_ff == ST_PUSH && left_ff == 2'h1) begin
                rsp_ff.pc <= req_ff.pc;
                rsp_ff.sfr_route <= 1'b0;
                rsp_ff.range_err <= 1'b0;
            end
        end
    end
    assign CORE_RSP = rsp_ff;
    assign CORE_RSP_VALID = rsp_valid_ff;

    // stack pointer: software load wins over a core step in the same cycle
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sp_ff <= SP_RESET;
        end else if (sp_load) begin
            if (wstrb_ff[0]) begin
                sp_ff[7:0] <= wdata_ff[7:0];
            end
            if (wstrb_ff[1]) begin
                sp_ff[15:8] <= esm_ff ? wdata_ff[15:8] : 8'h00;
            end
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // mode and bank control, sticky range error from push, pop or universal pointer
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            eif_ff <= 1'b0;
            esm_ff <= 1'b0;
            bank_ff <= BANK_RESET;
            err_ff <= 1'b0;
        end else begin
            if (do_wr && awaddr_ff == REG_MODE && wstrb_ff[0]) begin
                eif_ff <= wdata_ff[MODE_EIF_BIT];
                esm_ff <= wdata_ff[MODE_ESM_BIT];
            end
            if (do_wr && awaddr_ff == REG_BANK && wstrb_ff[0]) begin
                bank_ff <= wdata_ff[BANK_HI_BIT:BANK_LO_BIT];
            end
            // a new error wins over a clear in the same cycle
            if (accept && range_err) begin
                err_ff <= 1'b1;
            end else if (do_wr && awaddr_ff == REG_STATUS && wstrb_ff[0] &&
                         wdata_ff[STAT_ERR_BIT]) begin
                err_ff <= 1'b0;
            end
        end
    end

    // axi write channel: address and data held until both present
    assign AWREADY = !aw_hold_ff && !bvalid_ff;
    assign WREADY = !w_hold_ff && !bvalid_ff;
    assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign sp_load = do_wr && awaddr_ff == REG_SP;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= {AWADDR[11:2], 2'b00};
            end
            if (WVALID && WREADY) begin
                w_hold_ff <= 1'b1;
                wdata_ff <= WDATA;
                wstrb_ff <= WSTRB;
            end
            if (do_wr) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (awaddr_ff inside {REG_MODE, REG_SP, REG_BANK, REG_STATUS}) ?
                            RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;

    // register read mux
    always_comb begin
        reg_rd = 32'h0000_0000;
        reg_hit = 1'b1;
        unique case ({ARADDR[11:2], 2'b00})
            REG_MODE: begin
                reg_rd[MODE_EIF_BIT] = eif_ff;
                reg_rd[MODE_ESM_BIT] = esm_ff;
            end
            REG_SP: reg_rd[15:0] = sp_ff;
            REG_BANK: reg_rd[BANK_HI_BIT:BANK_LO_BIT] = bank_ff;
            REG_STATUS: begin
                reg_rd[STAT_BUSY_BIT] = state_ff != ST_IDLE;
                reg_rd[STAT_ERR_BIT] = err_ff;
            end
            default: reg_hit = 1'b0;
        endcase
    end

    // axi read channel: answer one cycle after the address
    assign ARREADY = !rvalid_ff;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= reg_rd;
            rresp_ff <= reg_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign RVALID = rvalid_ff;
    assign RDATA = rdata_ff;
    assign RRESP = rresp_ff;

    // helper values sampled by the checks
    logic [7:0] peek_stk;
    logic [7:0] peek_reg;
    assign peek_stk = (stk_idx < DMEM_LIMIT) ? mem[stk_idx[MEM_AW-1:0]] : 8'h00;
    assign peek_reg = mem[{6'h00, bank_ff, CORE_REQ.addr[2:0]}];

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    chk_push_incr: assert property (accept && CORE_REQ.op == OP_PUSH && !sp_load |=>
        sp_ff == sp_step($past(sp_ff), esm_ff, 1'b1)) else $error("push did not increment");
    chk_push_data: assert property (accept && CORE_REQ.op == OP_PUSH && !sp_load &&
        stk_up_idx < DMEM_LIMIT |=> peek_stk == $past(CORE_REQ.wdata))
        else $error("pushed byte not at new top");
    chk_pop_data: assert property (accept && CORE_REQ.op == OP_POP && !sp_load |=>
        CORE_RSP.rdata == $past(peek_stk) && sp_ff == sp_step($past(sp_ff), esm_ff, 1'b0))
        else $error("pop order wrong");
    chk_bank_map: assert property (accept && CORE_REQ.op == OP_REG_RD |=>
        CORE_RSP_VALID && CORE_RSP.rdata == $past(peek_reg)) else $error("bank map wrong");
    chk_bit_route: assert property (accept && CORE_REQ.op inside {OP_BIT_RD, OP_BIT_WR} &&
        CORE_REQ.addr[7] |=> CORE_RSP.sfr_route) else $error("high bit not routed");
    chk_intr_ext: assert property (accept && CORE_REQ.op == OP_INTR && eif_ff |=>
        state_ff == ST_PUSH [*3] ##1 CORE_RSP_VALID) else $error("ext frame not three bytes");
    chk_intr_std: assert property (accept && CORE_REQ.op == OP_INTR && !eif_ff |=>
        state_ff == ST_PUSH [*2] ##1 CORE_RSP_VALID) else $error("std frame not two bytes");
    chk_call_size: assert property (accept && CORE_REQ.op == OP_CALL |=>
        state_ff == ST_PUSH [*2] ##1 state_ff == ST_IDLE) else $error("call frame size wrong");
    chk_msb_mark: assert property (state_ff == ST_PUSH && idx_ff == 2'h2 |->
        mem_wd[7]) else $error("msb mark missing");

    cov_push_pop: cover property (accept && CORE_REQ.op == OP_PUSH ##[1:20]
        accept && CORE_REQ.op == OP_POP);
    cov_ext_intr: cover property (accept && CORE_REQ.op == OP_INTR && eif_ff);
    cov_ext_interrupt_return_instruction: cover property (accept && CORE_REQ.op == OP_INTERRUPT_RETURN_INSTRUCTION && eif_ff);
    cov_bit_write: cover property (accept && CORE_REQ.op == OP_BIT_WR && !CORE_REQ.addr[7]);
endmodule

//--- tb/core_model.sv
`timescale 1ns/100ps
// core stand-in: raises a request and holds it until the block takes it
module core_model
    import dmem_stack_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire core_req_type req_in,
    input wire logic ready,
    output core_req_type req,
    output logic valid
);
    // released payload is scrambled so a stale value cannot pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= 1'b0;
            req <= '0;
        end else if (start) begin
            valid <= 1'b1;
            req <= req_in;
        end else if (valid && ready) begin
            valid <= 1'b0;
            req <= core_req_type'(~req);
        end
    end
endmodule

//--- tb/test_internal_data_memory_stack.sv
`timescale 1ns/100ps
// bench for the data memory and stack block
module test_internal_data_memory_stack;
    import dmem_stack_pkg::*;
    logic CLK, ARST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
    logic RVALID, RREADY, CORE_REQ_VALID, CORE_REQ_READY, CORE_RSP_VALID, start;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, rd;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP;
    core_req_type req_in, CORE_REQ;
    core_rsp_type CORE_RSP, got;
    int failures, tests_run;
    localparam logic [22:0] RET_PC = 23'h412345;

    dmem_stack uut (.CLK(CLK), .ARST_N(ARST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .CORE_REQ(CORE_REQ), .CORE_REQ_VALID(CORE_REQ_VALID), .CORE_REQ_READY(CORE_REQ_READY),
        .CORE_RSP(CORE_RSP), .CORE_RSP_VALID(CORE_RSP_VALID));
    core_model core (.clk(CLK), .rst_n(ARST_N), .start(start), .req_in(req_in),
        .ready(CORE_REQ_READY), .req(CORE_REQ), .valid(CORE_REQ_VALID));

    // core clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a wait that ran out of cycles ends the run
    task automatic hang(input logic done);
        if (!done) begin
            failures++;
            finish_test();
        end
    endtask

    // register write; each channel held until taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic done;
        done = 1'b0;
        AWADDR <= a;
        WDATA <= d;
        {AWVALID, WVALID, BREADY} <= 3'h7;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) begin
                BREADY <= 1'b0;
                check("bresp", BRESP, resp);
                done = 1'b1;
            end
        end
        hang(done);
    endtask

    // register read into rd
    task automatic axi_rd(input logic [11:0] a, input logic [1:0] resp);
        logic done;
        done = 1'b0;
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'h3;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) begin
                RREADY <= 1'b0;
                rd = RDATA;
                check("rresp", RRESP, resp);
                done = 1'b1;
            end
        end
        hang(done);
    endtask

    // one core request through the model; answer lands in got
    task automatic op(input op_type o, input logic [15:0] a, input logic [7:0] d = 8'h0,
        input logic [22:0] pc = 23'h0);
        logic done;
        done = 1'b0;
        req_in <= '{op: o, addr: a, wdata: d, pc: pc};
        start <= 1'b1;
        @(posedge CLK);
        start <= 1'b0;
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge CLK);
            done = (CORE_RSP_VALID === 1'b1);
        end
        got = CORE_RSP;
        hang(done);
    endtask

    task automatic sp_is(input logic [15:0] v);
        axi_rd(REG_SP, RESP_OKAY);
        check("sp", rd[15:0], v);
    endtask

    // reset state, first push and pop
    task automatic test_reset();
        sp_is(SP_RESET);
        axi_rd(REG_MODE, RESP_OKAY);
        check("mode", rd, 32'h0);
        op(OP_PUSH, 16'h0, 8'ha5);
        sp_is(16'h0008);
        op(OP_DIR_RD, 16'h0008);
        check("first item", got.rdata, 8'ha5);
        op(OP_POP, 16'h0);
        check("pop", got.rdata, 8'ha5);
        sp_is(SP_RESET);
        $display("reset test done");
    endtask

    // banked registers and the bit area share the plain ram
    task automatic test_ram();
        for (int b = 0; b < 4; b++) begin
            axi_wr(REG_BANK, 32'(b) << BANK_LO_BIT, RESP_OKAY);
            op(OP_REG_WR, 16'h3, 8'h30 + 8'(b));
            op(OP_IND_RD, 16'(b * 8 + 3));
            check("bank", got.rdata, 8'h30 + 8'(b));
            op(OP_REG_RD, 16'h3);
            check("reg read", got.rdata, 8'h30 + 8'(b));
        end
        op(OP_IND_WR, 16'h0040, 8'h6c);
        op(OP_DIR_RD, 16'h0040);
        check("shared", got.rdata, 8'h6c);
        op(OP_DIR_WR, 16'h0021, 8'h0);
        op(OP_BIT_WR, 16'h000a, 8'h1);
        op(OP_DIR_RD, 16'h0021);
        check("bit byte", got.rdata, 8'h04);
        op(OP_BIT_WR, 16'h007f, 8'h1);
        op(OP_IND_RD, 16'h002f);
        check("last bit", got.rdata[7], 1'b1);
        op(OP_BIT_RD, 16'h0080);
        check("sfr route", got.sfr_route, 1'b1);
        $display("ram test done");
    endtask

    // return frames before and after the mode bits are set
    task automatic test_frames();
        op(OP_CALL, 16'h0, 8'h0, RET_PC);
        sp_is(16'h0009);
        op(OP_RET, 16'h0);
        check("ret", got.pc, 23'h002345);
        op(OP_INTR, 16'h0, 8'h0, RET_PC);
        op(OP_INTERRUPT_RETURN_INSTRUCTION, 16'h0);
        check("interrupt_return_instruction", got.pc, 23'h002345);
        axi_wr(REG_MODE, 32'h3, RESP_OKAY);
        op(OP_INTR, 16'h0, 8'h0, RET_PC);
        sp_is(16'h000a);
        op(OP_IND_RD, 16'h000a);
        check("top byte", got.rdata, 8'hc1);
        op(OP_INTERRUPT_RETURN_INSTRUCTION, 16'h0);
        check("interrupt_return_instruction ext", got.pc, RET_PC);
        op(OP_CALL, 16'h0, 8'h0, RET_PC);
        sp_is(16'h0009);
        op(OP_RET, 16'h0);
        op(OP_ECALL, 16'h0, 8'h0, RET_PC);
        sp_is(16'h000a);
        op(OP_ERET, 16'h0);
        check("eret", got.pc, RET_PC);
        $display("frame test done");
    endtask

    // stack above the low 256 bytes
    task automatic test_ext();
        axi_wr(REG_SP, 32'h03fe, RESP_OKAY);
        op(OP_PUSH, 16'h0, 8'h5a);
        sp_is(16'h03ff);
        op(OP_UPTR_RD, 16'h03ff);
        check("ext byte", got.rdata, 8'h5a);
        op(OP_UPTR_WR, 16'h0400, 8'h77);
        op(OP_UPTR_RD, 16'h0400);
        check("uptr", got.rdata, 8'h77);
        op(OP_UPTR_RD, 16'h0500);
        check("range", got.range_err, 1'b1);
        axi_rd(REG_STATUS, RESP_OKAY);
        check("sticky err", rd[STAT_ERR_BIT], 1'b1);
        axi_rd(12'h010, RESP_SLVERR);
        axi_wr(REG_MODE, 32'h0, RESP_OKAY);
        axi_wr(REG_SP, 32'h03fe, RESP_OKAY);
        sp_is(16'h00fe);
        $display("ext test done");
    endtask

    initial begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, start, ARST_N} = '0;
        {AWADDR, ARADDR, WDATA, req_in} = '0;
        WSTRB = 4'hf;
        {failures, tests_run} = '0;
        repeat (16) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        test_reset();
        test_ram();
        test_frames();
        test_ext();
        finish_test();
    end
endmodule
